// file: pkg/dmt_pkg.sv
// constants and carrier types for the data memory and table read block
package dmt_pkg;

  // ------------------------------------------------------------
  // data memory geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int GP_BANK_AW = 7;
  localparam logic [7:0] SFR_FIRST = 8'h00;
  localparam logic [7:0] SFR_LAST = 8'h7F;
  localparam logic [7:0] GP_FIRST = 8'h80;
  localparam logic [7:0] GP_LAST = 8'hFF;

  // ------------------------------------------------------------
  // special function addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IND_ZERO = 8'h00;
  localparam logic [7:0] ADDR_PTR_ZERO = 8'h01;
  localparam logic [7:0] ADDR_IND_ONE = 8'h02;
  localparam logic [7:0] ADDR_PTR_ONE = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_TAB_PTR_LO = 8'h07;
  localparam logic [7:0] ADDR_TAB_HIGH = 8'h08;
  localparam logic [7:0] ADDR_TAB_PTR_HI = 8'h09;
  localparam logic [7:0] ADDR_NV_CTRL = 8'h40;

  // ------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------
  localparam logic BANK_SEL_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam int BANK_BIT_POS = 0;
  localparam int PM_WORD_W = 16;
  localparam int PM_HI_LSB = 8;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dmt_req_s;

  typedef struct packed {
    logic nop;
    logic bank;
    logic [7:0] addr;
  } dmt_eff_s;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FETCH = 1'b1
  } dmt_state_e;

endpackage : dmt_pkg

// file: hdl/dmt_gp_bank.sv
// one bank of general purpose data memory
`timescale 1ns/100ps
`default_nettype none
module dmt_gp_bank #(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  import dmt_pkg::*;

  logic [DW-1:0] mem [2**AW];

  if (DW < 1 || AW < 1) begin : g_bad_geometry
    $error("dmt_gp_bank: bad geometry");
  end

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];

endmodule : dmt_gp_bank
`default_nettype wire

// file: hdl/dmt_data_memory_table_read.sv
// data memory with bank select, indirect access and table read path
//
// Summary of operation
// - table address is page high byte plus offset
// - table read loads upper word byte automatically
// - table high latch ignores software writes
// - table instructions occupy two instruction cycles
// - data memory is byte wide from zero
// - 00H-7FH special area, 80H-FFH general area
// - general locations read/write, some specials protected
// - larger variant has two general banks
// - specials shared, 40H only in bank one
// - unimplemented table high bits read zero
// - direct addressing reaches bank zero, except 40H which follows select
// - first pointer bank zero, second follows select
// - select bit resets zero except watchdog wake
`timescale 1ns/100ps
`default_nettype none
module dmt_data_memory_table_read #(
  parameter int NUM_BANKS = 2,
  parameter int PM_AW = 12,
  parameter int TAB_HI_BITS = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wdt_pd_wake,
  input wire dmt_pkg::dmt_req_s i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_busy,
  input wire logic i_tab_req,
  input wire logic [7:0] i_tab_dest,
  output logic o_pm_rd,
  output logic [PM_AW-1:0] o_pm_addr,
  input wire logic [15:0] i_pm_data,
  output logic o_bank_sel
);
  import dmt_pkg::*;

  if (NUM_BANKS < 1 || NUM_BANKS > 2 || PM_AW < 9 || PM_AW > 15 || TAB_HI_BITS < 1 || TAB_HI_BITS > 8) begin : g_bad_cfg
    $error("dmt_data_memory_table_read: unsupported parameters");
  end

  localparam int HI_W = PM_AW - 8;
  localparam logic [7:0] HI_MASK = 8'((9'h001 << TAB_HI_BITS) - 9'h001);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  dmt_state_e state, next_state;
  logic [7:0] pointer_zero, next_pointer_zero;
  logic [7:0] pointer_one, next_pointer_one;
  logic bank_select_bit, next_bank_select_bit;
  logic [7:0] tab_ptr_lo, next_tab_ptr_lo;
  logic [HI_W-1:0] tab_ptr_hi, next_tab_ptr_hi;
  logic [7:0] table_high_latch, next_table_high_latch;
  logic [7:0] nv_control_reg, next_nv_control_reg;
  logic [7:0] tab_dest, next_tab_dest;
  logic [7:0] rdata, next_rdata;
  logic rvalid, next_rvalid;
  logic pm_rd, next_pm_rd;
  logic [PM_AW-1:0] pm_addr, next_pm_addr;

  logic [7:0] sfr_mem [2**GP_BANK_AW];
  logic [7:0] gp_rd [NUM_BANKS];
  logic [7:0] gp_sel_rd;
  logic [7:0] tab_hi_rd;
  logic acc_valid;
  logic acc_wr;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  dmt_eff_s eff;
  logic is_gp;
  logic sfr_mem_we;

  // ------------------------------------------------------------
  // address resolution
  // ------------------------------------------------------------
  function automatic dmt_eff_s resolve(input logic [7:0] a, input logic [7:0] p0, input logic [7:0] p1,
                                       input logic b);
    dmt_eff_s e;
    e.nop = 1'b0;
    e.bank = 1'b0;
    e.addr = a;
    if (a == ADDR_IND_ZERO) begin
      e.addr = p0;
    end else if (a == ADDR_IND_ONE) begin
      e.addr = p1;
      e.bank = b;
    end
    if ((a == ADDR_IND_ZERO || a == ADDR_IND_ONE) && (e.addr == ADDR_IND_ZERO || e.addr == ADDR_IND_ONE)) begin
      e.nop = 1'b1;
    end
    return e;
  endfunction : resolve

  // table fetch owns the data path in its second cycle
  always_comb begin
    if (state == ST_FETCH) begin
      acc_valid = 1'b1;
      acc_wr = 1'b1;
      acc_addr = tab_dest;
      acc_wdata = i_pm_data[PM_HI_LSB-1:0];
    end else begin
      acc_valid = i_req.valid;
      acc_wr = i_req.wr;
      acc_addr = i_req.addr;
      acc_wdata = i_req.wdata;
    end
  end

  assign eff = resolve(acc_addr, pointer_zero, pointer_one, bank_select_bit);
  assign is_gp = (eff.addr >= GP_FIRST) && (eff.addr <= GP_LAST);

  // ------------------------------------------------------------
  // general purpose banks
  // ------------------------------------------------------------
  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    dmt_gp_bank #(
      .DW(DATA_W),
      .AW(GP_BANK_AW)
    ) u_bank (
      .i_clk(i_clk),
      .i_we(acc_valid && acc_wr && !eff.nop && is_gp && (eff.bank == 1'(g))),
      .i_addr(eff.addr[GP_BANK_AW-1:0]),
      .i_wdata(acc_wdata),
      .o_rdata(gp_rd[g])
    );
  end

  assign gp_sel_rd = (eff.bank && NUM_BANKS == 2) ? gp_rd[NUM_BANKS-1] : gp_rd[0];
  assign tab_hi_rd = {{(8-HI_W){1'b0}}, tab_ptr_hi};

  // ------------------------------------------------------------
  // generic special function storage
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (sfr_mem_we) begin
      sfr_mem[eff.addr[GP_BANK_AW-1:0]] <= acc_wdata;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pointer_zero = pointer_zero;
    next_pointer_one = pointer_one;
    next_bank_select_bit = bank_select_bit;
    next_tab_ptr_lo = tab_ptr_lo;
    next_tab_ptr_hi = tab_ptr_hi;
    next_table_high_latch = table_high_latch;
    next_nv_control_reg = nv_control_reg;
    next_tab_dest = tab_dest;
    next_rdata = rdata;
    next_rvalid = 1'b0;
    next_pm_rd = 1'b0;
    next_pm_addr = pm_addr;
    sfr_mem_we = 1'b0;

    // reads
    if (state == ST_IDLE && acc_valid && !acc_wr) begin
      next_rvalid = 1'b1;
      if (eff.nop) begin
        next_rdata = READ_ZERO;
      end else if (is_gp) begin
        next_rdata = gp_sel_rd;
      end else begin
        case (eff.addr)
          ADDR_IND_ZERO, ADDR_IND_ONE: next_rdata = READ_ZERO;
          ADDR_PTR_ZERO: next_rdata = pointer_zero;
          ADDR_PTR_ONE: next_rdata = pointer_one;
          ADDR_BANK_SEL: next_rdata = {7'h00, bank_select_bit};
          ADDR_TAB_PTR_LO: next_rdata = tab_ptr_lo;
          ADDR_TAB_PTR_HI: next_rdata = tab_hi_rd;
          ADDR_TAB_HIGH: next_rdata = table_high_latch;
          ADDR_NV_CTRL: next_rdata = bank_select_bit ? nv_control_reg : READ_ZERO;
          default: next_rdata = sfr_mem[eff.addr[GP_BANK_AW-1:0]];
        endcase
      end
    end

    // writes
    if (acc_valid && acc_wr && !eff.nop && !is_gp) begin
      case (eff.addr)
        ADDR_IND_ZERO, ADDR_IND_ONE: next_rdata = rdata;
        ADDR_PTR_ZERO: next_pointer_zero = acc_wdata;
        ADDR_PTR_ONE: next_pointer_one = acc_wdata;
        ADDR_BANK_SEL: next_bank_select_bit = (NUM_BANKS == 2) ? acc_wdata[BANK_BIT_POS] : BANK_SEL_RST;
        ADDR_TAB_PTR_LO: next_tab_ptr_lo = acc_wdata;
        ADDR_TAB_PTR_HI: next_tab_ptr_hi = acc_wdata[HI_W-1:0];
        ADDR_TAB_HIGH: next_table_high_latch = table_high_latch;
        ADDR_NV_CTRL: begin
          if (bank_select_bit) begin
            next_nv_control_reg = acc_wdata;
          end
        end
        default: sfr_mem_we = 1'b1;
      endcase
    end

    // table read sequencer
    case (state)
      ST_IDLE: begin
        if (i_tab_req) begin
          next_state = ST_FETCH;
          next_pm_rd = 1'b1;
          next_pm_addr = {tab_ptr_hi, tab_ptr_lo};
          next_tab_dest = i_tab_dest;
        end
      end
      ST_FETCH: begin
        next_state = ST_IDLE;
        next_table_high_latch = i_pm_data[PM_WORD_W-1:PM_HI_LSB] & HI_MASK;
      end
      default: next_state = ST_IDLE;
    endcase

    if (!i_resetn) begin
      next_state = ST_IDLE;
      next_pointer_zero = BYTE_RST;
      next_pointer_one = BYTE_RST;
      next_tab_ptr_lo = BYTE_RST;
      next_tab_ptr_hi = '0;
      next_table_high_latch = BYTE_RST;
      next_nv_control_reg = BYTE_RST;
      next_tab_dest = BYTE_RST;
      next_rdata = BYTE_RST;
      next_rvalid = 1'b0;
      next_pm_rd = 1'b0;
      next_pm_addr = '0;
      sfr_mem_we = 1'b0;
      if (!i_wdt_pd_wake) begin
        next_bank_select_bit = BANK_SEL_RST;
      end else begin
        next_bank_select_bit = bank_select_bit;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    state <= next_state;
    pointer_zero <= next_pointer_zero;
    pointer_one <= next_pointer_one;
    bank_select_bit <= next_bank_select_bit;
    tab_ptr_lo <= next_tab_ptr_lo;
    tab_ptr_hi <= next_tab_ptr_hi;
    table_high_latch <= next_table_high_latch;
    nv_control_reg <= next_nv_control_reg;
    tab_dest <= next_tab_dest;
    rdata <= next_rdata;
    rvalid <= next_rvalid;
    pm_rd <= next_pm_rd;
    pm_addr <= next_pm_addr;
  end

  assign o_rdata = rdata;
  assign o_rvalid = rvalid;
  assign o_busy = (state == ST_FETCH);
  assign o_pm_rd = pm_rd;
  assign o_pm_addr = pm_addr;
  assign o_bank_sel = bank_select_bit;

endmodule : dmt_data_memory_table_read
`default_nettype wire

// file: verif/dmt_checker.sv
// assertions on the ports of the data memory and table read block
`timescale 1ns/100ps
`default_nettype none
module dmt_checker
  import dmt_pkg::*;
#(
  parameter int PM_AW = 12
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_wdt_pd_wake,
  input wire dmt_pkg::dmt_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_busy,
  input wire logic i_tab_req,
  input wire logic [7:0] i_tab_dest,
  input wire logic o_pm_rd,
  input wire logic [PM_AW-1:0] o_pm_addr,
  input wire logic [15:0] i_pm_data,
  input wire logic o_bank_sel
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire rd_go = i_req.valid && !i_req.wr && !o_busy;
  wire tab_go = i_tab_req && !o_busy;
  wire bank_wr = i_req.valid && i_req.wr && !o_busy && i_req.addr == ADDR_BANK_SEL;
  read_answer_a: assert property (rd_go |=> o_rvalid) else $error("read not answered");
  read_quiet_a: assert property (!rd_go |=> !o_rvalid) else $error("stray read valid");
  tab_start_a: assert property (tab_go |=> o_busy && o_pm_rd) else $error("table fetch missing");
  busy_once_a: assert property (o_busy |=> !o_busy) else $error("busy too long");
  addr_hold_a: assert property (!tab_go |=> $stable(o_pm_addr)) else $error("fetch address moved");
  bank_write_a: assert property (bank_wr |=> o_bank_sel == $past(i_req.wdata[0])) else $error("bank write lost");
  bank_reset_a: assert property (disable iff (1'b0) !i_resetn && !i_wdt_pd_wake |=> !o_bank_sel)
    else $error("bank not reset");
  bank_wake_a: assert property (disable iff (1'b0) !i_resetn && i_wdt_pd_wake |=> $stable(o_bank_sel))
    else $error("bank lost on wake");
endmodule : dmt_checker
bind dmt_data_memory_table_read dmt_checker #(.PM_AW(PM_AW)) dmt_checker_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_wdt_pd_wake(i_wdt_pd_wake), .i_req(i_req),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy(o_busy), .i_tab_req(i_tab_req),
  .i_tab_dest(i_tab_dest), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data),
  .o_bank_sel(o_bank_sel));
`default_nettype wire

// file: verif/dmt_pm_model.sv
// program memory model answering table fetches
`timescale 1ns/100ps
`default_nettype none
module dmt_pm_model #(
  parameter int AW = 12
) (
  input wire logic i_clk,
  input wire logic i_pm_rd,
  input wire logic [AW-1:0] i_pm_addr,
  output logic [15:0] o_pm_data
);
  logic [15:0] last = 16'h0000;
  always_ff @(posedge i_clk) begin
    last <= o_pm_data;
  end
  // word valid only under the strobe, else a changing pattern
  always_comb begin
    if (i_pm_rd) o_pm_data = {i_pm_addr[7:0] ^ 8'h5A, i_pm_addr[7:0] ^ 8'hC3};
    else o_pm_data = ~last;
  end
endmodule : dmt_pm_model
`default_nettype wire

// file: verif/dmt_data_memory_table_read_bench.sv
// testbench for the data memory and table read block
`timescale 1ns/100ps
`default_nettype none
module dmt_data_memory_table_read_bench;
  import dmt_pkg::*;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wdt_pd_wake = 1'b0;
  dmt_req_s i_req = '0;
  logic i_tab_req = 1'b0;
  logic [7:0] i_tab_dest = 8'h00;
  logic [7:0] o_rdata;
  logic o_rvalid;
  logic o_busy;
  logic o_pm_rd;
  logic o_bank_sel;
  logic [11:0] o_pm_addr;
  logic [15:0] i_pm_data;
  logic [7:0] rd;
  int bad_count = 0;
  int n_compared = 0;
  always #5 i_clk = ~i_clk;
  dmt_data_memory_table_read #(.NUM_BANKS(2), .PM_AW(12), .TAB_HI_BITS(6)) dmt_data_memory_table_read_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_wdt_pd_wake(i_wdt_pd_wake), .i_req(i_req),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_busy(o_busy), .i_tab_req(i_tab_req),
    .i_tab_dest(i_tab_dest), .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data),
    .o_bank_sel(o_bank_sel));
  dmt_pm_model #(.AW(12)) dmt_pm_model_inst (.i_clk(i_clk), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr),
    .o_pm_data(i_pm_data));
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    @(negedge i_clk);
    i_req = '{1'b1, wr, addr, wd};
    @(negedge i_clk);
    rd = o_rdata;
    if (wr === 1'b0) chk("rvalid", o_rvalid, 1'b1);
    i_req.valid = 1'b0;
  endtask : acc
  task automatic rdchk(input string what, input logic [7:0] addr, input logic [7:0] exp);
    acc(1'b0, addr, 8'h00);
    chk(what, rd, exp);
  endtask : rdchk
  task automatic rst(input logic wake);
    @(negedge i_clk);
    i_wdt_pd_wake = wake;
    i_resetn = 1'b0;
    @(negedge i_clk);
    i_resetn = 1'b1;
    i_wdt_pd_wake = 1'b0;
  endtask : rst
  task automatic t_gp;
    chk("bank rst", o_bank_sel, 1'b0);
    rdchk("bank reg rst", ADDR_BANK_SEL, 8'h00);
    acc(1'b1, 8'h80, 8'h5A);
    acc(1'b1, 8'hFF, 8'hC3);
    acc(1'b1, 8'h10, 8'hE7);
    rdchk("gp 80", 8'h80, 8'h5A);
    rdchk("gp ff", 8'hFF, 8'hC3);
    rdchk("sfr 10", 8'h10, 8'hE7);
    $display("done t_gp");
  endtask : t_gp
  task automatic t_bank;
    acc(1'b1, 8'h80, 8'hA0);
    acc(1'b1, ADDR_BANK_SEL, 8'hFF);
    chk("bank sel", o_bank_sel, 1'b1);
    rdchk("bank reg", ADDR_BANK_SEL, 8'h01);
    acc(1'b1, ADDR_PTR_ONE, 8'h80);
    acc(1'b1, ADDR_IND_ONE, 8'hB1);
    rdchk("direct b0", 8'h80, 8'hA0);
    rdchk("ind one b1", ADDR_IND_ONE, 8'hB1);
    acc(1'b1, ADDR_PTR_ZERO, 8'h80);
    rdchk("ind zero b0", ADDR_IND_ZERO, 8'hA0);
    acc(1'b1, ADDR_NV_CTRL, 8'h3C);
    rdchk("nv b1", ADDR_NV_CTRL, 8'h3C);
    acc(1'b1, ADDR_BANK_SEL, 8'h00);
    rdchk("nv b0", ADDR_NV_CTRL, 8'h00);
    rdchk("ind one b0", ADDR_IND_ONE, 8'hA0);
    acc(1'b1, ADDR_NV_CTRL, 8'h55);
    acc(1'b1, ADDR_BANK_SEL, 8'h01);
    rdchk("nv kept", ADDR_NV_CTRL, 8'h3C);
    acc(1'b1, ADDR_BANK_SEL, 8'h00);
    $display("done t_bank");
  endtask : t_bank
  task automatic t_table;
    acc(1'b1, 8'h91, 8'h11);
    acc(1'b1, ADDR_TAB_PTR_HI, 8'h0F);
    acc(1'b1, ADDR_TAB_PTR_LO, 8'h06);
    @(negedge i_clk);
    i_tab_dest = 8'h90;
    i_tab_req = 1'b1;
    @(negedge i_clk);
    i_req = '{1'b1, 1'b1, 8'h91, 8'h77};
    chk("busy", o_busy, 1'b1);
    chk("pm rd", o_pm_rd, 1'b1);
    chk("pm addr", o_pm_addr, 12'hF06);
    @(negedge i_clk);
    i_req.valid = 1'b0;
    i_tab_req = 1'b0;
    chk("busy end", o_busy, 1'b0);
    rdchk("low byte", 8'h90, 8'h06 ^ 8'hC3);
    rdchk("high latch", ADDR_TAB_HIGH, (8'h06 ^ 8'h5A) & 8'h3F);
    acc(1'b1, ADDR_TAB_HIGH, 8'hFF);
    rdchk("latch ro", ADDR_TAB_HIGH, (8'h06 ^ 8'h5A) & 8'h3F);
    rdchk("busy drop", 8'h91, 8'h11);
    $display("done t_table");
  endtask : t_table
  task automatic t_wdt;
    acc(1'b1, ADDR_BANK_SEL, 8'h01);
    rst(1'b1);
    chk("bank wake", o_bank_sel, 1'b1);
    rst(1'b0);
    chk("bank reset", o_bank_sel, 1'b0);
    $display("done t_wdt");
  endtask : t_wdt
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    t_gp();
    t_bank();
    t_table();
    t_wdt();
    wrap_up();
  end
endmodule : dmt_data_memory_table_read_bench
`default_nettype wire
